// ### hw/pste_encoder.sv
`timescale 1ns/1ps
// Contract
// - At least one status code for every executed instruction.
// - Non-PC-relative flow change: marker then target address nibbles.
// - Data trace on: peripheral access gives marker then operand nibbles.
// - Stream goes into the on-chip trace buffer, not to pins.
// - Hold sequential codes, flush on other code, max count or data.
// - Status code is five bits wide.
// - Continue code 0x00 on later cycles of multi-cycle instructions.
// - Begin-one-instruction code 0x01 for ordinary instructions.
// - Code 0x03 after the instruction entering user mode.
// - Code 0x04 for pulse and write-debug-data, then marker and operand.
// - Code 0x05 for taken branch or program counter sync, address optional.
// - Code 0x07 when return-from-exception starts.
// - Data markers 0x08, 0x09, 0x0B; capture gated by data capture control.
// - Data marker precedes first data nibble by exactly one cycle; the code pushes that nibble on the next cycle the FIFO has room.
// - Address markers 0x0D or 0x0E lead address by one cycle; the code pushes the first nibble on the next cycle the FIFO has room.
// - Runs of 2 to 10 sequential instructions use 0x12 to 0x1A.
// - Exception, stopped, halted codes recorded twice, then suppressed.
// - Each trace buffer entry is six bits wide.

// Synchronous FIFO between the encoder and the trace buffer write port.
module pste_fifo
  import pste_pkg::*;
#(
  parameter int W = 6,
  parameter int D = 16
) (
  input  wire logic         i_sys_clk,
  input  wire logic         i_rst,
  input  wire logic         i_in_valid,
  output logic              o_in_ready,
  input  wire logic [W-1:0] i_in_data,
  output logic              o_out_valid,
  input  wire logic         i_out_ready,
  output logic [W-1:0]      o_out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem_q [D];
  logic [AW:0]  wr_q, wr_d, rd_q, rd_d;
  logic         push, pop;

  // Extra pointer bit tells full from empty.
  always_comb
  begin
    o_in_ready  = (wr_q[AW] == rd_q[AW]) || (wr_q[AW-1:0] != rd_q[AW-1:0]);
    o_out_valid = (wr_q != rd_q);
    o_out_data  = mem_q[rd_q[AW-1:0]];
    push        = i_in_valid && o_in_ready;
    pop         = o_out_valid && i_out_ready;
    wr_d        = push ? wr_q + 1'b1 : wr_q;
    rd_d        = pop ? rd_q + 1'b1 : rd_q;
  end

  // Pointers and storage; storage needs no reset.
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      wr_q <= '0;
      rd_q <= '0;
    end
    else
    begin
      wr_q <= wr_d;
      rd_q <= rd_d;
    end
    if (push)
      mem_q[wr_q[AW-1:0]] <= i_in_data;
  end
endmodule : pste_fifo

// Status/debug data encoder with run compression feeding the trace buffer.
module pste_encoder
  import pste_pkg::*;
(
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst,
  input  wire logic        i_ev_valid,
  output logic             o_ev_ready,
  input  wire pste_kind_e  i_ev_kind,
  input  wire logic        i_ev_indirect,
  input  wire logic [23:0] i_ev_target,
  input  wire logic [31:0] i_ev_data,
  input  wire logic [1:0]  i_ev_size,
  input  wire logic        i_per_valid,
  output logic             o_per_ready,
  input  wire logic [31:0] i_per_data,
  input  wire logic [1:0]  i_per_size,
  input  wire logic        i_data_capture_control,
  input  wire logic [1:0]  i_branch_target_capture,
  output logic             o_tb_valid,
  input  wire logic        i_tb_ready,
  output logic [ENT_W-1:0] o_tb_entry
);
  pste_state_e      st_q, st_d;
  logic [3:0]       run_q, run_d, nib_q, nib_d, c_nib;
  logic [1:0]       rep_q, rep_d;
  logic [4:0]       last_q, last_d, code_q, code_d, mark_q, mark_d;
  logic [4:0]       c_code, c_mark; // Five-bit status codes.
  logic             hasc_q, hasc_d, hasm_q, hasm_d, c_hasc, c_hasm;
  logic [31:0]      sh_q, sh_d, c_sh;
  logic             fifo_rdy, ev_take, per_take, push, is_mode;
  logic [ENT_W-1:0] push_ent;

  // Accumulated code for a run of n sequential instructions.
  function automatic logic [4:0] acc_code(input logic [3:0] n);
    acc_code = (n == 4'h1) ? C_BEGIN : C_RUN2 + {1'b0, n} - 5'h02;
  endfunction : acc_code

  // Operands stall the core while a previous packet drains.
  always_comb
  begin
    // Ready is settled first so that the take below never sees a stale value.
    o_ev_ready  = (st_q == S_IDLE) && fifo_rdy;
    ev_take     = i_ev_valid && o_ev_ready;
    o_per_ready = !i_data_capture_control ||
                  ((st_q == S_IDLE) && fifo_rdy && !i_ev_valid);
    per_take    = i_per_valid && o_per_ready && i_data_capture_control;
  end

  // Decode of the accepted event into code, marker and operand.
  always_comb
  begin
    c_code = C_BEGIN;
    c_hasc = 1'b1;
    c_mark = C_DAT4;
    c_hasm = 1'b0;
    c_sh   = i_ev_data;
    c_nib  = NIB_B4;
    if (!ev_take)
    begin
      c_hasc = 1'b0;
      c_hasm = per_take;
      c_sh   = i_per_data;
    end
    else
    begin
      case (i_ev_kind)
        K_CONT:  c_code = C_CONT;
        K_SEQ:   c_code = C_BEGIN;
        K_USER:  c_code = C_USER;
        K_PULSE: c_code = C_PULSE;
        K_WDATA:
        begin
          c_code = C_PULSE;
          c_hasm = 1'b1;
        end
        K_BRANCH, K_SYNC:
        begin
          c_code = C_TAKEN;
          c_hasm = (i_ev_indirect || i_ev_kind == K_SYNC) &&
                   (i_branch_target_capture != BTB_OFF);
          c_sh   = {8'h00, i_ev_target};
          c_mark = (i_branch_target_capture == BTB_TWO) ? C_ADR2 : C_ADR3;
          c_nib  = (i_branch_target_capture == BTB_TWO) ? NIB_B2 : NIB_B3;
        end
        K_RTE:   c_code = C_RTE;
        K_EXC:   c_code = C_EXC;
        K_STOP:  c_code = C_STOP;
        K_HALT:  c_code = C_HALT;
        default: c_hasc = 1'b0; // Undefined kinds emit nothing.
      endcase
    end
    // Data marker and nibble count follow the operand size.
    if ((!ev_take) || (i_ev_kind == K_WDATA))
    begin
      case (ev_take ? i_ev_size : i_per_size)
        SZ_BYTE:
        begin
          c_mark = C_DAT1;
          c_nib  = NIB_B1;
        end
        SZ_WORD:
        begin
          c_mark = C_DAT2;
          c_nib  = NIB_B2;
        end
        default:
        begin
          c_mark = C_DAT4;
          c_nib  = NIB_B4;
        end
      endcase
    end
    // Long modes record two copies, then go quiet.
    is_mode = (c_code == C_EXC) || (c_code == C_STOP) || (c_code == C_HALT);
    if (c_hasc && is_mode && (c_code == last_q) && (rep_q == REP_MAX))
      c_hasc = 1'b0;
  end

  // Sequencer: flush, status code, marker, then nibbles.
  always_comb
  begin
    st_d     = st_q;
    run_d    = run_q;
    rep_d    = rep_q;
    last_d   = last_q;
    code_d   = code_q;
    hasc_d   = hasc_q;
    mark_d   = mark_q;
    hasm_d   = hasm_q;
    sh_d     = sh_q;
    nib_d    = nib_q;
    push     = 1'b0;
    push_ent = {ENT_STAT, C_CONT};
    case (st_q)
      S_IDLE:
      begin
        if (ev_take || per_take)
        begin
          if (ev_take)
          begin
            last_d = c_code;
            rep_d  = (c_code == last_q && rep_q != REP_MAX) ?
                     rep_q + 2'h1 : (c_code == last_q ? rep_q : 2'h1);
          end
          if (ev_take && i_ev_kind == K_SEQ)
          begin
            // Hold back plain begin codes until something breaks the run.
            if (run_q + 4'h1 == RUN_MAX)
            begin
              push     = 1'b1;
              push_ent = {ENT_STAT, acc_code(RUN_MAX)};
              run_d    = 4'h0;
            end
            else
              run_d = run_q + 4'h1;
          end
          else
          begin
            code_d = c_code;
            hasc_d = c_hasc;
            mark_d = c_mark;
            hasm_d = c_hasm;
            sh_d   = c_sh;
            nib_d  = c_nib;
            if (run_q != 4'h0)
            begin
              push     = 1'b1;
              push_ent = {ENT_STAT, acc_code(run_q)};
              run_d    = 4'h0;
              st_d     = c_hasc ? S_CODE : (c_hasm ? S_MARK : S_IDLE);
            end
            else if (c_hasc)
            begin
              push     = 1'b1;
              push_ent = {ENT_STAT, c_code};
              st_d     = c_hasm ? S_MARK : S_IDLE;
            end
            else if (c_hasm)
            begin
              push     = 1'b1;
              push_ent = {ENT_STAT, c_mark};
              st_d     = S_NIB;
            end
          end
        end
      end
      S_CODE:
      begin
        push     = fifo_rdy;
        push_ent = {ENT_STAT, code_q};
        if (fifo_rdy)
          st_d = hasm_q ? S_MARK : S_IDLE;
      end
      S_MARK:
      begin
        push     = fifo_rdy;
        push_ent = {ENT_STAT, mark_q};
        if (fifo_rdy)
          st_d = S_NIB;
      end
      S_NIB:
      begin
        push     = fifo_rdy;
        push_ent = {ENT_DATA, 1'b0, sh_q[3:0]};
        if (fifo_rdy)
        begin
          sh_d  = sh_q >> 4;
          nib_d = nib_q - 4'h1;
          if (nib_q == 4'h1)
            st_d = S_IDLE;
        end
      end
      default: st_d = S_IDLE;
    endcase
  end

  // Sequencer registers.
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      st_q   <= S_IDLE;
      run_q  <= 4'h0;
      rep_q  <= 2'h0;
      last_q <= C_CONT;
      code_q <= C_CONT;
      hasc_q <= 1'b0;
      mark_q <= C_CONT;
      hasm_q <= 1'b0;
      sh_q   <= 32'h0;
      nib_q  <= 4'h0;
    end
    else
    begin
      st_q   <= st_d;
      run_q  <= run_d;
      rep_q  <= rep_d;
      last_q <= last_d;
      code_q <= code_d;
      hasc_q <= hasc_d;
      mark_q <= mark_d;
      hasm_q <= hasm_d;
      sh_q   <= sh_d;
      nib_q  <= nib_d;
    end
  end

  // Six-bit entries buffered toward the trace buffer.
  pste_fifo #(
    .W (ENT_W),
    .D (FIFO_DEPTH)
  ) u_fifo (
    .i_sys_clk   (i_sys_clk),
    .i_rst       (i_rst),
    .i_in_valid  (push),
    .o_in_ready  (fifo_rdy),
    .i_in_data   (push_ent),
    .o_out_valid (o_tb_valid),
    .i_out_ready (i_tb_ready),
    .o_out_data  (o_tb_entry)
  );

  // Checks on the produced stream.
  property p_no_reserved;
    @(posedge i_sys_clk) disable iff (i_rst)
    (push && push_ent[5] == ENT_STAT) |-> !(push_ent[4:0] inside
      {5'h02, 5'h06, 5'h0a, 5'h0c, 5'h0f, 5'h10, 5'h11, 5'h1d});
  endproperty
  a_no_reserved: assert property (p_no_reserved)
    else $error("Reserved status code pushed.");
  property p_mark_lead;
    @(posedge i_sys_clk) disable iff (i_rst)
    (st_q == S_MARK && push) |=> (st_q == S_NIB && push_ent[5] == ENT_DATA);
  endproperty
  a_mark_lead: assert property (p_mark_lead)
    else $error("Marker not followed by a nibble.");
  property p_nib_order;
    @(posedge i_sys_clk) disable iff (i_rst)
    (st_q == S_NIB && push && nib_q != 4'h1) |=>
      (sh_q == ($past(sh_q) >> 4));
  endproperty
  a_nib_order: assert property (p_nib_order)
    else $error("Nibbles not shifted low first.");
  property p_run_max;
    @(posedge i_sys_clk) disable iff (i_rst) run_q < RUN_MAX;
  endproperty
  a_run_max: assert property (p_run_max)
    else $error("Run count passed its maximum.");
  property p_flush;
    @(posedge i_sys_clk) disable iff (i_rst)
    ((ev_take && i_ev_kind != K_SEQ || per_take) && run_q != 4'h0) |->
      (push && push_ent == {ENT_STAT, acc_code(run_q)}) ##1 run_q == 4'h0;
  endproperty
  a_flush: assert property (p_flush)
    else $error("Held run not flushed.");
  property p_rep;
    @(posedge i_sys_clk) disable iff (i_rst) rep_q <= REP_MAX;
  endproperty
  a_rep: assert property (p_rep)
    else $error("Mode repeat count too high.");
  property p_cont;
    @(posedge i_sys_clk) disable iff (i_rst)
    (ev_take && i_ev_kind == K_CONT && run_q == 4'h0) |->
      push && push_ent == {ENT_STAT, C_CONT};
  endproperty
  a_cont: assert property (p_cont)
    else $error("Continue code missing.");
  property p_wdata;
    @(posedge i_sys_clk) disable iff (i_rst)
    (ev_take && i_ev_kind == K_WDATA && run_q == 4'h0) |->
      push_ent == {ENT_STAT, C_PULSE} ##1 st_q == S_MARK;
  endproperty
  a_wdata: assert property (p_wdata)
    else $error("Write-debug-data packet malformed.");
  c_run10: cover property (@(posedge i_sys_clk)
    push && push_ent == {ENT_STAT, acc_code(RUN_MAX)});
  c_addr: cover property (@(posedge i_sys_clk)
    st_q == S_MARK && mark_q == C_ADR3 && push);
  c_data: cover property (@(posedge i_sys_clk) per_take ##[1:3] st_q == S_NIB);
endmodule : pste_encoder

// ### hw/pste_pkg.sv
package pste_pkg;
  // Trace buffer entry: bit 5 set marks a debug data nibble.
  localparam int        ENT_W      = 6;
  localparam int        FIFO_DEPTH = 16;
  localparam logic      ENT_DATA   = 1'b1;
  localparam logic      ENT_STAT   = 1'b0;
  // Processor status codes.
  localparam logic [4:0] C_CONT   = 5'h00;
  localparam logic [4:0] C_BEGIN  = 5'h01;
  localparam logic [4:0] C_USER   = 5'h03;
  localparam logic [4:0] C_PULSE  = 5'h04;
  localparam logic [4:0] C_TAKEN  = 5'h05;
  localparam logic [4:0] C_RTE    = 5'h07;
  localparam logic [4:0] C_DAT1   = 5'h08;
  localparam logic [4:0] C_DAT2   = 5'h09;
  localparam logic [4:0] C_DAT4   = 5'h0b;
  localparam logic [4:0] C_ADR2   = 5'h0d;
  localparam logic [4:0] C_ADR3   = 5'h0e;
  localparam logic [4:0] C_RUN2   = 5'h12;
  localparam logic [4:0] C_EXC    = 5'h1c;
  localparam logic [4:0] C_STOP   = 5'h1e;
  localparam logic [4:0] C_HALT   = 5'h1f;
  // Run compression and repeat limits.
  localparam logic [3:0] RUN_MAX  = 4'ha;
  localparam logic [1:0] REP_MAX  = 2'h2;
  // Nibble counts per marker.
  localparam logic [3:0] NIB_B1   = 4'h2;
  localparam logic [3:0] NIB_B2   = 4'h4;
  localparam logic [3:0] NIB_B3   = 4'h6;
  localparam logic [3:0] NIB_B4   = 4'h8;
  // Operand size and branch-target capture settings.
  localparam logic [1:0] SZ_BYTE  = 2'h0;
  localparam logic [1:0] SZ_WORD  = 2'h1;
  localparam logic [1:0] BTB_OFF  = 2'h0;
  localparam logic [1:0] BTB_TWO  = 2'h1;
  // Core events, one per accepted cycle.
  typedef enum logic [3:0] {
    K_CONT = 4'h0, K_SEQ = 4'h1, K_USER = 4'h2, K_PULSE = 4'h3,
    K_WDATA = 4'h4, K_BRANCH = 4'h5, K_SYNC = 4'h6, K_RTE = 4'h7,
    K_EXC = 4'h8, K_STOP = 4'h9, K_HALT = 4'ha
  } pste_kind_e;
  typedef enum logic [3:0] {
    S_IDLE = 4'b0001, S_CODE = 4'b0010, S_MARK = 4'b0100, S_NIB = 4'b1000
  } pste_state_e;
endpackage : pste_pkg

// ### tb/pste_encoder_tb.sv
`timescale 1ns/1ps
`define CHK(g, e) \
  begin \
    samples_checked++; \
    if ((g) !== (e)) \
    begin \
      miscompares++; \
      $display("[FAIL] %0t got %h exp %h", $time, g, e); \
    end \
  end

module pste_encoder_tb
  import pste_pkg::*;
;
  logic             i_sys_clk, i_rst, i_ev_valid, i_ev_indirect;
  logic             i_per_valid, i_data_capture_control, i_tb_ready;
  logic             o_ev_ready, o_per_ready, o_tb_valid;
  pste_kind_e       i_ev_kind, last_k;
  logic [23:0]      i_ev_target;
  logic [31:0]      i_ev_data, i_per_data;
  logic [1:0]       i_ev_size, i_per_size, i_branch_target_capture;
  logic [1:0]       stall_mode;
  logic [ENT_W-1:0] o_tb_entry;
  logic [5:0]       exp_q[$];
  int               miscompares, samples_checked, run_n, rep_n;

  pste_encoder pste_encoder_inst (.i_sys_clk, .i_rst, .i_ev_valid,
    .o_ev_ready, .i_ev_kind, .i_ev_indirect, .i_ev_target, .i_ev_data,
    .i_ev_size, .i_per_valid, .o_per_ready, .i_per_data, .i_per_size,
    .i_data_capture_control, .i_branch_target_capture, .o_tb_valid,
    .i_tb_ready, .o_tb_entry);

  pste_tbuf_model pste_tbuf_model_inst (.i_sys_clk, .i_rst,
    .i_valid(o_tb_valid), .i_entry(o_tb_entry),
    .i_stall_mode(stall_mode), .o_ready(i_tb_ready));

  // Free-running system clock.
  initial
  begin
    i_sys_clk = 1'b0;
    forever #5 i_sys_clk = ~i_sys_clk;
  end

  // A hang ends the run as a failure rather than running forever.
  initial
  begin
    #900000;
    $display("[FAIL] %0t run limit reached", $time);
    miscompares++;
    stop_test();
  end

  task automatic stop_test();
    $display("checked %0d mismatched %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test

  function automatic void put(logic [5:0] e);
    exp_q.push_back(e);
  endfunction : put

  // Nibbles are flagged as data and go least significant first.
  function automatic void put_nib(logic [31:0] v, int n);
    for (int i = 0; i < n; i++)
      put({2'b10, v[4*i +: 4]});
  endfunction : put_nib

  // A held run must leave as one code before anything else is recorded.
  function automatic void flush_run();
    if (run_n == 1)
      put({1'b0, C_BEGIN});
    else if (run_n > 1)
      put({1'b0, C_RUN2 + 5'(run_n - 2)});
    run_n = 0;
  endfunction : flush_run

  function automatic void put_data(logic [31:0] d, logic [1:0] sz);
    flush_run();
    put({1'b0, sz == SZ_BYTE ? C_DAT1 : sz == SZ_WORD ? C_DAT2 : C_DAT4});
    put_nib(d, sz == SZ_BYTE ? 2 : sz == SZ_WORD ? 4 : 8);
  endfunction : put_data

  function automatic void model_ev(pste_kind_e k, logic ind,
                                  logic [23:0] t, logic [31:0] d,
                                  logic [1:0] sz);
    logic [1:0] b;
    b = i_branch_target_capture;
    rep_n = (k == last_k) ? rep_n + 1 : 1;
    last_k = k;
    if (k == K_SEQ)
    begin
      run_n++;
      if (run_n == 10)
        flush_run();
      return;
    end
    flush_run();
    case (k)
      K_CONT:  put({1'b0, C_CONT});
      K_USER:  put({1'b0, C_USER});
      K_PULSE: put({1'b0, C_PULSE});
      K_RTE:   put({1'b0, C_RTE});
      K_WDATA:
      begin
        put({1'b0, C_PULSE});
        put_data(d, sz);
      end
      K_BRANCH, K_SYNC:
      begin
        put({1'b0, C_TAKEN});
        if (b != BTB_OFF && (ind || k == K_SYNC))
        begin
          put({1'b0, b == BTB_TWO ? C_ADR2 : C_ADR3});
          put_nib({8'h00, t}, b == BTB_TWO ? 4 : 6);
        end
      end
      default:
        if (rep_n <= 2)
          put({1'b0, k == K_EXC ? C_EXC : k == K_STOP ? C_STOP : C_HALT});
    endcase
  endfunction : model_ev

  // One event (pv low) or peripheral access (pv high), held until taken.
  task automatic xfer(logic pv, pste_kind_e k, logic ind, logic [23:0] t,
                      logic [31:0] d, logic [1:0] sz);
    int n;
    @(negedge i_sys_clk);
    i_ev_valid = !pv;
    i_per_valid = pv;
    i_ev_kind = k;
    i_ev_indirect = ind;
    i_ev_target = t;
    i_ev_data = d;
    i_per_data = d;
    i_ev_size = sz;
    i_per_size = sz;
    #1;
    for (n = 0; n < 300 && (pv ? o_per_ready : o_ev_ready) !== 1'b1; n++)
    begin
      @(negedge i_sys_clk);
      #1;
    end
    if (n == 300)
    begin
      $display("[FAIL] %0t request never taken", $time);
      miscompares++;
      stop_test();
    end
    @(posedge i_sys_clk);
    if (!pv)
      model_ev(k, ind, t, d, sz);
    else if (i_data_capture_control)
      put_data(d, sz);
  endtask : xfer

  // Lets the stream settle, then compares the recorded buffer contents.
  task automatic drain(string name);
    int n;
    @(negedge i_sys_clk);
    i_ev_valid = 1'b0;
    i_per_valid = 1'b0;
    stall_mode = 2'h0;
    for (n = 0; n < 400 && (o_tb_valid ||
         pste_tbuf_model_inst.store_q.size() < exp_q.size()); n++)
      @(negedge i_sys_clk);
    // A stream that never settles is a failure, not a silent pass.
    if (n == 400)
    begin
      $display("[FAIL] %0t stream did not settle", $time);
      miscompares++;
      stop_test();
    end
    repeat (3) @(negedge i_sys_clk);
    `CHK(pste_tbuf_model_inst.store_q.size(), exp_q.size())
    for (n = 0; n < exp_q.size() &&
         n < pste_tbuf_model_inst.store_q.size(); n++)
      `CHK(pste_tbuf_model_inst.store_q[n], exp_q[n])
    exp_q.delete();
    pste_tbuf_model_inst.store_q.delete();
    $display("test %s done", name);
  endtask : drain

  // Main sequence: corner cases first, then a random mix with stalls.
  initial
  begin
    {i_rst, i_data_capture_control} = 2'b11;
    {i_ev_valid, i_ev_indirect, i_per_valid} = 3'h0;
    {i_ev_target, i_ev_data, i_per_data} = '0;
    {i_ev_size, i_per_size, stall_mode} = 6'h00;
    i_ev_kind = K_CONT;
    i_branch_target_capture = BTB_TWO;
    last_k = K_SEQ;
    void'($urandom(32'h763a00b9));
    repeat (8) @(posedge i_sys_clk);
    @(negedge i_sys_clk);
    i_rst = 1'b0;
    xfer(0, K_WDATA, 0, 0, 32'ha5, SZ_BYTE);
    drain("wdata_byte");
    repeat (3) xfer(0, K_SEQ, 0, 0, 0, 0);
    xfer(0, K_RTE, 0, 0, 0, 0);
    drain("run_three");
    xfer(0, K_SEQ, 0, 0, 0, 0);
    xfer(0, K_USER, 0, 0, 0, 0);
    repeat (2) xfer(0, K_CONT, 0, 0, 0, 0);
    drain("begin_user");
    repeat (11) xfer(0, K_SEQ, 0, 0, 0, 0);
    xfer(0, K_PULSE, 0, 0, 0, 0);
    drain("run_max");
    for (int b = 0; b < 4; b++)
    begin
      i_branch_target_capture = 2'(b);
      xfer(0, K_BRANCH, 1, 24'($urandom), 0, 0);
      xfer(0, K_BRANCH, 0, 24'($urandom), 0, 0);
      xfer(0, K_SYNC, 0, 24'($urandom), 0, 0);
      drain("branch");
    end
    for (int k = 8; k < 11; k++)
      repeat (3) xfer(0, pste_kind_e'(k), 0, 0, 0, 0);
    drain("repeat_limit");
    xfer(0, K_SEQ, 0, 0, 0, 0);
    for (int s = 0; s < 3; s++)
      xfer(1, K_CONT, 0, 0, $urandom, 2'(s));
    drain("periph");
    i_data_capture_control = 1'b0;
    xfer(1, K_CONT, 0, 0, 32'h1234, SZ_WORD);
    xfer(0, K_PULSE, 0, 0, 0, 0);
    drain("periph_off");
    i_data_capture_control = 1'b1;
    for (int s = 0; s < 4; s++)
      xfer(0, K_WDATA, 0, 0, $urandom, 2'(s));
    drain("wdata_sizes");
    stall_mode = 2'h2;
    repeat (16) xfer(0, K_PULSE, 0, 0, 0, 0);
    @(negedge i_sys_clk);
    #1;
    `CHK(o_ev_ready, 1'b0)
    `CHK(o_per_ready, 1'b0)
    `CHK(o_tb_valid, 1'b1)
    drain("fifo_full");
    i_branch_target_capture = 2'($urandom);
    stall_mode = 2'h1;
    repeat (300)
      xfer(1'($urandom_range(5) == 0), pste_kind_e'($urandom_range(10)),
           1'($urandom), 24'($urandom), $urandom, 2'($urandom));
    xfer(0, K_PULSE, 0, 0, 0, 0);
    drain("random");
    stop_test();
  end
endmodule : pste_encoder_tb

// ### tb/pste_tbuf_model.sv
`timescale 1ns/1ps
// Behavioural trace buffer that keeps every accepted entry in order.
module pste_tbuf_model
  import pste_pkg::*;
(
  input  wire logic             i_sys_clk,
  input  wire logic             i_rst,
  input  wire logic             i_valid,
  input  wire logic [ENT_W-1:0] i_entry,
  input  wire logic [1:0]       i_stall_mode,
  output logic                  o_ready
);
  logic [ENT_W-1:0] store_q[$];

  initial o_ready = 1'b1;

  // Ready moves only after an edge; mode 1 stalls at random, mode 2 fully.
  always @(posedge i_sys_clk)
  begin
    if (!i_rst && i_valid && o_ready)
      store_q.push_back(i_entry);
    case (i_stall_mode)
      2'h1: o_ready <= ($urandom_range(3) != 0);
      2'h2: o_ready <= 1'b0;
      default: o_ready <= 1'b1;
    endcase
  end
endmodule : pste_tbuf_model
